// file: pra_arbiter.sv
// Two-level rotating priority arbiter for the PCI bus
// Function
// - Arbitrate among the own master and four external masters.
// - Enable the arbiter only if the select strap is low at reset.
// - When enabled, the shared chip-select pins become request inputs.
// - The low group is one slot in the high-priority rotation.
// - Each visit of the low slot moves on to the next low member.
// - A group bit of one puts a master high, zero puts it low.
// - With all masters in one group, plain round robin applies.
// - Priority is re-evaluated whenever FRAME# asserts.
// - Between re-evaluations the top pending request is granted.
// - On a busy bus a higher request preempts the active grant on the next clock.
// - After a high master's transaction the next master is top, initiator last; after a low one the own master is top.
// - A grant unused for 16 idle cycles is removed.
// - A timed-out master waits until it drops its request a clock.
// - On an idle bus a new grant comes a clock after the old drops.
// - On a busy bus one grant may replace another in one clock.
`timescale 1ns/100ps
`default_nettype none
`include "pra_params.svh"
module pra_arbiter
(
   input wire logic clk,
   input wire logic rst_n,
   input wire pra_pkg::pra_pins_t pins,
   input wire logic own_req,
   input wire logic [4:0] group_high,
   input wire logic [2:0] xbus_cs_n,
   output logic own_gnt,
   output logic [3:0] ext_gnt_n,
   output logic [3:0] shared_pin_out,
   output logic [3:0] shared_pin_oe,
   output logic arbiter_enabled
);
   import pra_pkg::*;

   // ==========================================================
   // Functions
   function automatic logic [4:0] pra_onehot(input logic [2:0] idx);
      pra_onehot = `PRA_ONE_MASTER << idx;
   endfunction

   // Scan the high ring from hp; the low slot scans low members from lp
   function automatic pra_pick_t pra_pick(input logic [4:0] req,
      input logic [4:0] hi, input logic [2:0] hp, input logic [2:0] lp);
      pra_pick_t r;
      logic [2:0] p;
      logic [2:0] q;
      r = '0;
      for (int i = 0; i < `PRA_RING_LEN; i++)
      begin
         p = 3'((int'(hp) + i) % `PRA_RING_LEN);
         if (!r.found && p != `PRA_LOW_SLOT && hi[p] && req[p])
            r = '{found: 1'b1, idx: p};
         else if (!r.found && p == `PRA_LOW_SLOT)
         begin
            for (int j = 0; j < `PRA_NUM_MASTERS; j++)
            begin
               q = 3'((int'(lp) + j) % `PRA_NUM_MASTERS);
               if (!r.found && !hi[q] && req[q])
                  r = '{found: 1'b1, idx: q};
            end
         end
      end
      pra_pick = r;
   endfunction

   // ==========================================================
   // Pin synchronisers: three stages, a change counts once 2 and 3 agree
   pra_pins_t sync1;
   pra_pins_t sync2;
   pra_pins_t sync3;
   pra_pins_t clean;
   logic arb_en;
   logic frame_prev;

   always_ff @(posedge clk)
   begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         clean <= '{frame_n: 1'b1, irdy_n: 1'b1, req_n: 4'hF, strap: 1'b1};
      else
         clean <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & clean);
   end

   // Strap is caught by the clock while reset is held
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         arb_en <= ~sync3.strap & (sync2.strap == sync3.strap);
   end

   // ==========================================================
   // Arbitration state
   logic [4:0] gnt;
   logic [2:0] hi_ptr;
   logic [2:0] lo_ptr;
   logic [4:0] blocked;
   logic [4:0] to_cnt;

   wire [4:0] req_raw = {~clean.req_n, own_req};
   wire [4:0] req_eff = req_raw & ~blocked;
   // One group only means one plain ring of all masters
   wire all_same = (group_high == `PRA_NO_MASTERS) ||
                   (group_high == `PRA_ALL_MASTERS);
   wire [4:0] hi_eff = all_same ? `PRA_ALL_MASTERS : group_high;
   wire pra_pick_t win = pra_pick(req_eff, hi_eff, hi_ptr, lo_ptr);
   wire [4:0] win_vec = pra_onehot(win.idx);
   wire gnt_any = |gnt;
   wire bus_busy = ~clean.frame_n | ~clean.irdy_n;
   wire bus_idle = ~bus_busy;
   wire frame_start = frame_prev & ~clean.frame_n;
   wire [2:0] init_idx = gnt[1] ? 3'h1 : gnt[2] ? 3'h2 :
                         gnt[3] ? 3'h3 : gnt[4] ? 3'h4 : `PRA_OWN_IDX;
   wire init_hi = hi_eff[init_idx];
   wire [2:0] init_next = 3'((int'(init_idx) + 1) % `PRA_NUM_MASTERS);
   wire timeout = gnt_any && bus_idle &&
                  (to_cnt == `PRA_TIMEOUT_CYC - 5'h01);
   wire [4:0] next_gnt =
      !arb_en ? `PRA_NO_MASTERS :
      timeout ? `PRA_NO_MASTERS :
      !win.found ? `PRA_NO_MASTERS :
      (gnt == win_vec) ? gnt :
      (gnt_any && bus_idle) ? `PRA_NO_MASTERS :
      win_vec;
   // Set wins over clear: a timeout in the clearing cycle still blocks
   wire [4:0] next_blocked = (blocked & req_raw) |
                             (timeout ? gnt : `PRA_NO_MASTERS);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         gnt <= `PRA_NO_MASTERS;
         blocked <= `PRA_NO_MASTERS;
         to_cnt <= 5'h00;
         frame_prev <= 1'b1;
      end
      else
      begin
         gnt <= next_gnt;
         blocked <= next_blocked;
         frame_prev <= clean.frame_n;
         if (gnt_any && bus_idle && gnt == next_gnt)
            to_cnt <= to_cnt + 5'h01;
         else
            to_cnt <= 5'h00;
      end
   end

   // Rotation moves only at a transaction start
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hi_ptr <= `PRA_OWN_IDX;
         lo_ptr <= `PRA_PTR_RESET;
      end
      else if (frame_start && gnt_any)
      begin
         if (init_hi)
            hi_ptr <= 3'(int'(init_idx) + 1);
         else
         begin
            hi_ptr <= `PRA_OWN_IDX;
            lo_ptr <= init_next;
         end
      end
   end

   // ==========================================================
   // Outputs, all registered
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         own_gnt <= 1'b0;
         ext_gnt_n <= 4'hF;
         shared_pin_out <= 4'hF;
         shared_pin_oe <= 4'h0;
         arbiter_enabled <= 1'b0;
      end
      else
      begin
         own_gnt <= next_gnt[0];
         ext_gnt_n <= ~next_gnt[4:1];
         // Chip selects only reach the pins while the arbiter is off
         shared_pin_out <= {1'b1, xbus_cs_n};
         shared_pin_oe <= arb_en ? 4'h0 : 4'h7;
         arbiter_enabled <= arb_en;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_grants_clear: assert property (
      @(posedge clk) disable iff (1'b0)
      !rst_n |=> (!own_gnt && ext_gnt_n == 4'hF && hi_ptr == `PRA_OWN_IDX))
      else $error("grant or pointer wrong after reset");
   a_disabled_no_grant: assert property (
      !arb_en |=> (!own_gnt && ext_gnt_n == 4'hF))
      else $error("grant while arbiter disabled");
   a_pins_repurposed: assert property (
      arb_en && $past(arb_en) |-> shared_pin_oe == 4'h0)
      else $error("shared pins driven while arbiter enabled");
   a_grant_onehot: assert property (
      $onehot0(gnt) && (gnt == {~ext_gnt_n, own_gnt}))
      else $error("grant outputs not one-hot");
   a_idle_no_swap: assert property (
      (gnt_any && bus_idle) |=> (gnt == $past(gnt) || gnt == 5'h00))
      else $error("grant swapped in one clock on idle bus");
   a_busy_preempt: assert property (
      (arb_en && bus_busy && win.found && gnt_any && gnt != win_vec)
      |=> gnt == $past(win_vec))
      else $error("higher request not granted next clock");
   sequence s_idle_grant_wait;
      (gnt_any && bus_idle && to_cnt == `PRA_TIMEOUT_CYC - 5'h01);
   endsequence
   a_timeout_drop: assert property (
      s_idle_grant_wait |=> (gnt == 5'h00 && (blocked & $past(gnt)) != 0))
      else $error("unused grant not removed after timeout");
   a_blocked_no_grant: assert property (
      (blocked & next_gnt) == 5'h00)
      else $error("grant to a blocked master");
   a_high_rotate: assert property (
      (frame_start && gnt_any && init_hi) |=> hi_ptr == $past(init_idx) + 3'h1)
      else $error("high ring did not rotate past initiator");
   a_low_rotate: assert property (
      (frame_start && gnt_any && !init_hi)
      |=> (lo_ptr == $past(init_next) && hi_ptr == `PRA_OWN_IDX))
      else $error("low group did not advance");
endmodule
`default_nettype wire

// file: pra_params.svh
// Constants of the two-level rotating bus arbiter
`ifndef PRA_ARBITER_PARAMS_SVH
`define PRA_ARBITER_PARAMS_SVH
`define PRA_NUM_MASTERS 5
`define PRA_NUM_EXT 4
`define PRA_RING_LEN 6
`define PRA_LOW_SLOT 3'h5
`define PRA_OWN_IDX 3'h0
`define PRA_PTR_RESET 3'h0
`define PRA_TIMEOUT_CYC 5'h10
`define PRA_ONE_MASTER 5'h01
`define PRA_NO_MASTERS 5'h00
`define PRA_ALL_MASTERS 5'h1F
`endif

// file: pra_pkg.sv
// Types shared by the bus arbiter
`default_nettype none
package pra_pkg;
   // Pins that arrive from outside the clock domain
   typedef struct packed {
      logic frame_n;
      logic irdy_n;
      logic [3:0] req_n;
      logic strap;
   } pra_pins_t;
   // Found flag and master index of an arbitration winner
   typedef struct packed {
      logic found;
      logic [2:0] idx;
   } pra_pick_t;
endpackage
`default_nettype wire

// file: pra_ext_masters.sv
// Behavioural model of the four external bus masters
`timescale 1ns/100ps
`default_nettype none
module pra_ext_masters
(
   input wire logic clk,
   input wire logic [3:0] want,
   input wire logic use_bus,
   input wire logic [3:0] gnt_n,
   output logic [3:0] req_n,
   output logic frame_n,
   output logic irdy_n
);
   logic [2:0] busy;
   assign req_n = ~want;
   // Four busy cycles, then four idle ones before a master may start again
   assign frame_n = (busy < 3'h4);
   assign irdy_n = (busy < 3'h4);
   initial busy = 3'h0;
   always @(negedge clk)
   begin
      if (busy != 3'h0)
         busy <= busy - 3'h1;
      else if (use_bus && ((~gnt_n & want) != 4'h0))
         busy <= 3'h7;
   end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the two-level rotating bus arbiter
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import pra_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b0;
   logic own_req = 1'b0;
   logic use_bus = 1'b0;
   logic [4:0] group_high = 5'h1F;
   logic [3:0] want = 4'h0;
   logic [3:0] rq_n;
   logic fr_n;
   logic ir_n;
   pra_pins_t pins;
   logic own_gnt;
   logic [3:0] ext_gnt_n;
   logic [3:0] pin_oe;
   logic [3:0] pin_out;
   logic [2:0] xcs = 3'h5;
   logic arb_on;
   logic prev;
   int err_count = 0;
   int comparisons = 0;
   int n;
   assign pins = {fr_n, ir_n, rq_n, strap};
   always #20 clk = ~clk;
   pra_arbiter u_dut (.clk(clk), .rst_n(rst_n), .pins(pins),
      .own_req(own_req), .group_high(group_high), .xbus_cs_n(xcs),
      .own_gnt(own_gnt), .ext_gnt_n(ext_gnt_n), .shared_pin_out(pin_out),
      .shared_pin_oe(pin_oe), .arbiter_enabled(arb_on));
   pra_ext_masters u_masters (.clk(clk), .want(want), .use_bus(use_bus),
      .gnt_n(ext_gnt_n), .req_n(rq_n), .frame_n(fr_n), .irdy_n(ir_n));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_for(input logic [4:0] exp);
      n = 0;
      while ({own_gnt, ext_gnt_n} !== exp && n < 200)
      begin
         prev = own_gnt;
         @(negedge clk);
         n++;
      end
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      chk({own_gnt, ext_gnt_n}, 8'h0F);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk({arb_on, pin_oe}, strap ? 8'h07 : 8'h10);
   endtask
   task automatic t_strap_off();
      strap = 1'b1;
      do_reset();
      own_req = 1'b1;
      want = 4'hF;
      // Chip selects are only driven while the arbiter is deselected
      xcs = 3'h2;
      repeat (12) @(negedge clk);
      chk({own_gnt, ext_gnt_n}, 8'h0F);
      chk({pin_oe, pin_out}, 8'h7A);
      own_req = 1'b0;
      want = 4'h0;
      $display("test strap off done");
   endtask
   task automatic t_own();
      do_reset();
      own_req = 1'b1;
      want = 4'h2;
      repeat (12) @(negedge clk);
      chk({own_gnt, ext_gnt_n}, 8'h1F);
      own_req = 1'b0;
      wait_for(5'h0D);
      chk({prev, ext_gnt_n}, 8'h0D);
      own_req = 1'b1;
      wait_for(5'h1F);
      chk(n < 4, 8'h1);
      own_req = 1'b0;
      $display("test own and preemption done");
   endtask
   task automatic t_timeout();
      wait_for(5'h0D);
      n = 0;
      while (ext_gnt_n === 4'hD && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk(n >= 16 && n <= 17, 8'h1);
      repeat (10) @(negedge clk);
      chk(ext_gnt_n, 8'h0F);
      want = 4'h0;
      repeat (4) @(negedge clk);
      want = 4'h2;
      wait_for(5'h0D);
      chk(ext_gnt_n, 8'h0D);
      want = 4'h0;
      $display("test timeout done");
   endtask
   task automatic rot(input logic [4:0] g, input logic [3:0] w,
                      input logic [23:0] seq);
      logic [3:0] last;
      do_reset();
      group_high = g;
      want = w;
      use_bus = 1'b1;
      last = 4'hF;
      for (int i = 0; i < 6; i++)
      begin
         n = 0;
         while ((ext_gnt_n === 4'hF || ext_gnt_n === last) && n < 300)
         begin
            @(negedge clk);
            n++;
         end
         last = ext_gnt_n;
         chk(ext_gnt_n, seq[23 - 4 * i -: 4]);
      end
      want = 4'h0;
      use_bus = 1'b0;
      repeat (10) @(negedge clk);
      $display("test rotation done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      t_own();
      t_timeout();
      rot(5'h1F, 4'h3, 24'hEDEDED);
      rot(5'h00, 4'h3, 24'hEDEDED);
      rot(5'h03, 4'hF, 24'hEDEBE7);
      t_strap_off();
      complete_run();
   end
   initial
   begin
      #(40 * 20000);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
